// ==== rtl/bus_timing_pkg.sv ====
package bus_timing_pkg;

    // ----------------------------------------------------------------
    // register map: printed offsets are indices, byte address = 4*index
    // ----------------------------------------------------------------
    localparam int          APB_AW         = 18;
    localparam logic [15:0] IO_CFG_IDX     = 16'hf902;
    localparam logic [15:0] ZONE0_CFG_IDX  = 16'hf904;
    localparam logic [15:0] MODE_CTRL_IDX  = 16'hf906;
    localparam logic [15:0] STATUS_IDX     = 16'hf908;
    localparam logic [17:0] IO_CFG_ADDR    = {IO_CFG_IDX, 2'b00};
    localparam logic [17:0] ZONE0_CFG_ADDR = {ZONE0_CFG_IDX, 2'b00};
    localparam logic [17:0] MODE_CTRL_ADDR = {MODE_CTRL_IDX, 2'b00};
    localparam logic [17:0] STATUS_ADDR    = {STATUS_IDX, 2'b00};

    // ----------------------------------------------------------------
    // zone configuration fields
    // ----------------------------------------------------------------
    localparam logic [15:0] CFG_RESET      = 16'h069f;
    localparam logic [15:0] IO_CFG_MASK    = 16'h029f;
    localparam logic [15:0] ZONE0_CFG_MASK = 16'h0eff;
    localparam int          WAIT_LSB       = 0;
    localparam int          WAIT_W         = 3;
    localparam int          HOLD_LSB       = 3;
    localparam int          HOLD_W         = 2;
    localparam int          BW_BIT         = 7;
    localparam int          POST_IDLE_ENABLE_BIT       = 9;
    localparam int          PRE_IDLE_ENABLE_BIT       = 10;
    localparam int          FRE_BIT        = 11;

    // ----------------------------------------------------------------
    // mode control and status fields
    // ----------------------------------------------------------------
    localparam logic [15:0] MODE_CTRL_RESET = 16'h0001;
    localparam logic [15:0] MODE_CTRL_MASK  = 16'h0003;
    localparam int          EWR_BIT         = 0;
    localparam int          FEA_BIT         = 1;
    localparam int          STAT_ZONE_LSB   = 0;
    localparam int          STAT_BUSY_BIT   = 3;
    localparam int          STAT_WAIT_LSB   = 4;
    localparam int          STAT_HOLD_LSB   = 8;

    // ----------------------------------------------------------------
    // address ranges and fixed cycle counts
    // ----------------------------------------------------------------
    localparam logic [15:0] FLASH_HI   = 16'hbfff;
    localparam logic [15:0] RAM_LO     = 16'he000;
    localparam logic [15:0] RAM_HI     = 16'he7ff;
    localparam logic [15:0] PERIPH_LO  = 16'hf000;
    localparam logic [15:0] EEPROM_HI  = 16'hf27f;
    localparam logic [15:0] PORTS_LO   = 16'hfb00;
    localparam logic [15:0] PORTS_HI   = 16'hfbff;
    localparam logic [3:0]  BASE_WAIT_CYC   = 4'h1;
    localparam logic [3:0]  PERIPH_WAIT_CYC = 4'h1;
    localparam logic [3:0]  EE_SLOW_WAIT_CYC = 4'h1;

    typedef enum logic [2:0] {
        ZONE_FLASH, ZONE_RAM, ZONE_EEPROM, ZONE_PORTS, ZONE_PERIPH,
        ZONE_OTHER
    } zone_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        write;
    } cpu_req_t;

    typedef struct packed {
        logic [3:0] wait_cyc;
        logic [1:0] hold_cyc;
        logic       fast;
        logic       wide;
    } cyc_timing_t;

    typedef struct packed {
        logic idle;
        logic addr;
        logic wait_st;
        logic data;
        logic hold;
    } bus_phase_t;

endpackage : bus_timing_pkg

// ==== rtl/zone_decoder.sv ====
module zone_decoder (
    input  wire logic [15:0]          addr,
    output bus_timing_pkg::zone_t     zone
);
    import bus_timing_pkg::*;

    // ports window is checked before the general peripheral range
    always_comb begin
        if (addr <= FLASH_HI) begin
            zone = ZONE_FLASH;
        end else if (addr >= RAM_LO && addr <= RAM_HI) begin
            zone = ZONE_RAM;
        end else if (addr >= PORTS_LO && addr <= PORTS_HI) begin
            zone = ZONE_PORTS;
        end else if (addr >= PERIPH_LO && addr <= EEPROM_HI) begin
            zone = ZONE_EEPROM;
        end else if (addr >= PERIPH_LO) begin
            zone = ZONE_PERIPH;
        end else begin
            zone = ZONE_OTHER;
        end
    end

endmodule : zone_decoder

// ==== rtl/cycle_counter.sv ====
module cycle_counter #(
    parameter int W = 4
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         dec,
    output logic      [W-1:0] count
);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            count <= '0;
        end else if (load) begin
            count <= load_val;
        end else if (dec && count != '0) begin
            count <= W'(count - W'(1));
        end
    end

endmodule : cycle_counter

// ==== rtl/bus_wait_hold_timing.sv ====
// Register access over APB was chosen for this implementation.
module bus_wait_hold_timing (
    input  wire logic                         core_clk,
    input  wire logic                         rst_n,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [17:0]                  paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         req_valid,
    input  wire bus_timing_pkg::cpu_req_t     req,
    output logic                              req_ready,
    output bus_timing_pkg::bus_phase_t        phase,
    output logic                              cyc_done,
    output logic                              bus_wide_16
);
    import bus_timing_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_POST, ST_PRE, ST_ADDR, ST_WAIT, ST_DATA, ST_HOLD
    } state_t;

    state_t      state_reg;
    state_t      state_next;
    logic [15:0] io_cfg_reg;
    logic [15:0] zone0_cfg_reg;
    logic [15:0] mode_ctrl_reg;
    cyc_timing_t tim_reg;
    cyc_timing_t tim_in;
    zone_t       zone_in;
    zone_t       last_zone_reg;
    logic        last_valid_reg;
    logic        last_post_reg;
    logic        pre_pend_reg;
    logic        post_in;
    logic        pre_in;
    logic        post_en_in;
    logic        cnt_load;
    logic        cnt_dec;
    logic [3:0]  cnt_val;
    logic [3:0]  cnt;
    logic        accept;
    logic        apb_setup;
    logic        apb_wr;
    logic        addr_hit;
    logic [15:0] rd_mux;
    logic [15:0] status_word;

    // ----------------------------------------------------------------
    // configuration fields
    // ----------------------------------------------------------------
    wire logic [2:0] io_wait = io_cfg_reg[WAIT_LSB +: WAIT_W];
    wire logic [1:0] io_hold = io_cfg_reg[HOLD_LSB +: HOLD_W];
    wire logic [2:0] z0_wait = zone0_cfg_reg[WAIT_LSB +: WAIT_W];
    wire logic [1:0] z0_hold = zone0_cfg_reg[HOLD_LSB +: HOLD_W];
    wire logic       fast_read_enable     = zone0_cfg_reg[FRE_BIT];
    wire logic       early_write_sel     = mode_ctrl_reg[EWR_BIT];
    wire logic       fea     = mode_ctrl_reg[FEA_BIT];

    // ----------------------------------------------------------------
    // APB slave, zero wait: pready rises in every access phase
    // ----------------------------------------------------------------
    assign apb_setup = psel & ~penable;
    assign apb_wr    = psel & penable & pready & pwrite;
    assign addr_hit  = paddr == IO_CFG_ADDR || paddr == ZONE0_CFG_ADDR ||
                       paddr == MODE_CTRL_ADDR || paddr == STATUS_ADDR;

    always_comb begin
        status_word = '0;
        status_word[STAT_ZONE_LSB +: 3] = last_zone_reg;
        status_word[STAT_BUSY_BIT]      = state_reg != ST_IDLE;
        status_word[STAT_WAIT_LSB +: 4] = tim_reg.wait_cyc;
        status_word[STAT_HOLD_LSB +: 2] = tim_reg.hold_cyc;
    end

    always_comb begin
        unique case (paddr)
            IO_CFG_ADDR:    rd_mux = io_cfg_reg;
            ZONE0_CFG_ADDR: rd_mux = zone0_cfg_reg;
            MODE_CTRL_ADDR: rd_mux = mode_ctrl_reg;
            STATUS_ADDR:    rd_mux = status_word;
            default:        rd_mux = '0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= apb_setup;
            pslverr <= apb_setup & ~addr_hit;
            prdata  <= (apb_setup & ~pwrite) ? {16'h0000, rd_mux} : '0;
        end
    end

    // emulation bits are stored as written in zone0_cfg_reg and masked to zero in io_cfg_reg; software keeps them zero
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            io_cfg_reg    <= CFG_RESET;
            zone0_cfg_reg <= CFG_RESET;
            mode_ctrl_reg <= MODE_CTRL_RESET;
        end else if (apb_wr) begin
            if (paddr == IO_CFG_ADDR) begin
                io_cfg_reg <= pwdata[15:0] & IO_CFG_MASK;
            end
            if (paddr == ZONE0_CFG_ADDR) begin
                zone0_cfg_reg <= pwdata[15:0] & ZONE0_CFG_MASK;
            end
            if (paddr == MODE_CTRL_ADDR) begin
                mode_ctrl_reg <= pwdata[15:0] & MODE_CTRL_MASK;
            end
        end
    end

    // ----------------------------------------------------------------
    // per-access timing from zone, direction and configuration
    // ----------------------------------------------------------------
    zone_decoder u_zone_decoder (
        .addr (req.addr),
        .zone (zone_in)
    );

    always_comb begin
        tim_in = '0;
        tim_in.wide = 1'b1;
        unique case (zone_in)
            ZONE_FLASH: begin
                tim_in.wide = zone0_cfg_reg[BW_BIT];
                if (fast_read_enable) begin
                    // fast mode drops the wait and hold fields
                    tim_in.fast = ~req.write;
                    tim_in.wait_cyc = req.write ?
                        BASE_WAIT_CYC + {3'b000, early_write_sel} : '0;
                end else begin
                    tim_in.wait_cyc = BASE_WAIT_CYC + {1'b0, z0_wait} +
                        (req.write ? {3'b000, early_write_sel} : 4'h0);
                    tim_in.hold_cyc = z0_hold;
                end
            end
            ZONE_RAM: begin
                tim_in.wait_cyc = '0;
            end
            ZONE_EEPROM: begin
                tim_in.wait_cyc = (req.write || !fea) ?
                    EE_SLOW_WAIT_CYC : '0;
            end
            ZONE_PORTS: begin
                tim_in.wide = io_cfg_reg[BW_BIT];
                // write timing follows the early-write bit
                tim_in.wait_cyc = BASE_WAIT_CYC +
                    (req.write ? {3'b000, early_write_sel} : 4'h0) +
                    (fast_read_enable ? 4'h0 : {1'b0, io_wait});
                tim_in.hold_cyc = fast_read_enable ? 2'b00 : io_hold;
            end
            default: begin
                tim_in.wait_cyc = PERIPH_WAIT_CYC;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // zone change idle cycles
    // ----------------------------------------------------------------
    assign accept     = state_reg == ST_IDLE && req_valid;
    assign post_en_in = (zone_in == ZONE_PORTS && io_cfg_reg[POST_IDLE_ENABLE_BIT]) ||
                        (zone_in == ZONE_FLASH && zone0_cfg_reg[POST_IDLE_ENABLE_BIT]);
    assign post_in    = last_valid_reg && last_post_reg &&
                        zone_in != last_zone_reg;
    assign pre_in     = zone0_cfg_reg[PRE_IDLE_ENABLE_BIT] &&
                        (!last_valid_reg || zone_in != last_zone_reg);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tim_reg        <= '0;
            last_zone_reg  <= ZONE_OTHER;
            last_valid_reg <= 1'b0;
            last_post_reg  <= 1'b0;
            pre_pend_reg   <= 1'b0;
        end else if (accept) begin
            tim_reg        <= tim_in;
            last_zone_reg  <= zone_in;
            last_valid_reg <= 1'b1;
            last_post_reg  <= post_en_in;
            pre_pend_reg   <= pre_in;
        end
    end

    // ----------------------------------------------------------------
    // bus cycle sequencer
    // ----------------------------------------------------------------
    cycle_counter #(.W (4)) u_cycle_counter (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .load     (cnt_load),
        .load_val (cnt_val),
        .dec      (cnt_dec),
        .count    (cnt)
    );

    // waits follow the address slot, holds close the cycle
    always_comb begin
        state_next = state_reg;
        cnt_load   = 1'b0;
        cnt_dec    = 1'b0;
        cnt_val    = '0;
        unique case (state_reg)
            ST_IDLE: begin
                if (req_valid) begin
                    cnt_load = 1'b1;
                    cnt_val  = tim_in.wait_cyc;
                    if (post_in) begin
                        state_next = ST_POST;
                    end else if (pre_in) begin
                        state_next = ST_PRE;
                    end else begin
                        state_next = ST_ADDR;
                    end
                end
            end
            ST_POST: begin
                state_next = pre_pend_reg ? ST_PRE : ST_ADDR;
            end
            ST_PRE: begin
                state_next = ST_ADDR;
            end
            ST_ADDR: begin
                if (tim_reg.fast) begin
                    state_next = ST_IDLE;
                end else if (cnt != '0) begin
                    state_next = ST_WAIT;
                end else begin
                    state_next = ST_DATA;
                end
            end
            ST_WAIT: begin
                cnt_dec = 1'b1;
                if (cnt == 4'h1) begin
                    state_next = ST_DATA;
                end
            end
            ST_DATA: begin
                cnt_load   = 1'b1;
                cnt_val    = {2'b00, tim_reg.hold_cyc};
                state_next = tim_reg.hold_cyc != '0 ? ST_HOLD : ST_IDLE;
            end
            ST_HOLD: begin
                cnt_dec = 1'b1;
                if (cnt == 4'h1) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // phase, req_ready and cyc_done registered from the next state so they align with it; bus_wide_16 latched on accept
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            phase       <= '0;
            req_ready   <= 1'b1;
            cyc_done    <= 1'b0;
            bus_wide_16 <= 1'b1;
        end else begin
            phase.idle    <= state_next == ST_POST || state_next == ST_PRE;
            phase.addr    <= state_next == ST_ADDR;
            phase.wait_st <= state_next == ST_WAIT;
            phase.data    <= state_next == ST_DATA;
            phase.hold    <= state_next == ST_HOLD;
            req_ready     <= state_next == ST_IDLE;
            cyc_done      <= state_reg != ST_IDLE && state_next == ST_IDLE;
            if (accept) begin
                bus_wide_16 <= tim_in.wide;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [3:0] wait_run, hold_run;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wait_run <= '0;
            hold_run <= '0;
        end else begin
            wait_run <= phase.wait_st ? 4'(wait_run + 4'h1) : '0;
            hold_run <= phase.hold ? 4'(hold_run + 4'h1) : '0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    wait_count_a: assert property (
        $fell(phase.wait_st) |-> wait_run == tim_reg.wait_cyc)
        else $error("wait cycle count differs from programmed timing");
    hold_count_a: assert property (
        $fell(phase.hold) |-> hold_run == 4'(tim_reg.hold_cyc) && cyc_done)
        else $error("hold cycle count differs from programmed timing");
    fast_read_a: assert property (
        accept && zone_in == ZONE_FLASH && !req.write && fast_read_enable &&
        !post_in && !pre_in |=> phase.addr ##1 cyc_done && req_ready)
        else $error("fast flash read did not finish in one clock");
    flash_rd_a: assert property (
        accept && zone_in == ZONE_FLASH && !req.write && !fast_read_enable |->
        tim_in.wait_cyc == 4'(z0_wait) + 4'h1 && tim_in.hold_cyc == z0_hold)
        else $error("normal flash read timing wrong");
    ram_zero_a: assert property (
        phase.addr && last_zone_reg == ZONE_RAM |=>
        phase.data ##1 cyc_done)
        else $error("ram access took extra cycles");
    periph_wait_a: assert property (
        accept && zone_in == ZONE_PERIPH |->
        tim_in.wait_cyc == 4'h1 && tim_in.hold_cyc == 2'b00)
        else $error("peripheral access timing wrong");
    ports_win_a: assert property (
        req.addr[15:8] == 8'hfb |-> zone_in == ZONE_PORTS)
        else $error("ports window not chosen first");
    post_idle_a: assert property (
        accept && post_in |=> phase.idle ##1 !phase.wait_st)
        else $error("post idle cycle missing");
    wait_order_a: assert property (
        $fell(phase.wait_st) |-> phase.data && !phase.hold)
        else $error("wait cycles not followed by data slot");
    cfg_reset_a: assert property (
        !$past(rst_n) |-> io_cfg_reg == CFG_RESET &&
        zone0_cfg_reg == CFG_RESET)
        else $error("zone registers not at reset value");

    fast_read_c: cover property (phase.addr ##1 cyc_done);
    hold_seen_c: cover property ($fell(phase.hold));
    pre_idle_c:  cover property (accept && pre_in && !post_in);
    apb_err_c:   cover property (pready && pslverr);

endmodule : bus_wait_hold_timing

// ==== test/zone_model.sv ====
module zone_model (
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    input  wire bus_timing_pkg::bus_phase_t phase,
    input  wire logic                       cyc_done,
    output logic [15:0]                     counts,
    output logic                            ord_ok
);
    timeunit 1ns;
    timeprecision 1ns;
    import bus_timing_pkg::*;
    logic [3:0] ci, cw, ch, cd;
    logic       bad, seen;
    // one access ends with cyc_done; phase is all zero in that cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            {ci, cw, ch, cd, bad, seen} <= '0;
            counts <= '0;
            ord_ok <= 1'b0;
        end else if (cyc_done) begin
            counts <= {ci, cw, ch, cd};
            ord_ok <= !bad;
            {ci, cw, ch, cd, bad, seen} <= '0;
        end else begin
            ci <= ci + {3'b0, phase.idle};
            cw <= cw + {3'b0, phase.wait_st};
            ch <= ch + {3'b0, phase.hold};
            cd <= cd + {3'b0, phase.data};
            if (phase.data) seen <= 1'b1;
            // waits belong before the data slot, holds after it
            if ((phase.wait_st && seen) || (phase.hold && !seen))
                bad <= 1'b1;
        end
    end
endmodule : zone_model

// ==== test/test_bus_wait_hold_timing.sv ====
module test_bus_wait_hold_timing;
    timeunit 1ns;
    timeprecision 1ns;
    import bus_timing_pkg::*;
    logic        core_clk, rst_n, psel, penable, pwrite, req_valid;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, e, req_ready, cyc_done, bus_wide_16;
    logic        ord_ok;
    logic [15:0] counts;
    cpu_req_t    req;
    bus_phase_t  phase;
    int          mismatches, checks;
    logic [3:0]  wv [3] = '{4'h0, 4'h7, 4'h2};
    logic [3:0]  hv [3] = '{4'h0, 4'h3, 4'h1};

    bus_wait_hold_timing dut (.core_clk(core_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .phase(phase), .cyc_done(cyc_done),
        .bus_wide_16(bus_wide_16));
    zone_model zone (.core_clk(core_clk), .rst_n(rst_n), .phase(phase),
        .cyc_done(cyc_done), .counts(counts), .ord_ok(ord_ok));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task close_out;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    task fail(input string m);
        mismatches++;
        $display("CHECK FAILED %0t %s", $time, m);
        close_out();
    endtask : fail

    task chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            mismatches++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
        end
    endtask : chk

    task apb(input logic w, input logic [17:0] a, input logic [15:0] d);
        int i;
        @(posedge core_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {16'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (i == 16) fail("apb timeout");
    endtask : apb

    // idles, waits, holds, data slots of one cpu access
    task acc(input logic [15:0] a, input logic w, input logic [3:0] ei,
             input logic [3:0] ew, input logic [3:0] eh,
             input logic [3:0] ed);
        int i;
        @(posedge core_clk);
        req_valid <= 1'b1; req <= '{addr: a, write: w};
        for (i = 0; i < 32; i++) begin
            @(posedge core_clk);
            if (req_ready === 1'b1) break;
        end
        req_valid <= 1'b0;
        if (i == 32) fail("accept timeout");
        for (i = 0; i < 64; i++) begin
            @(posedge core_clk);
            if (cyc_done === 1'b1) break;
        end
        if (i == 64) fail("access timeout");
        #1;
        chk({counts, 15'h0, ord_ok}, {ei, ew, eh, ed, 15'h0, 1'b1});
    endtask : acc

    initial begin
        {rst_n, psel, penable, pwrite, req_valid} = '0;
        {paddr, pwdata, req} = '0;
        {mismatches, checks} = '0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        apb(0, IO_CFG_ADDR, 16'h0); chk(q, 32'h0000_069f);
        apb(0, ZONE0_CFG_ADDR, 16'h0); chk(q, 32'h0000_069f);
        apb(0, 18'h0_0000, 16'h0); chk({31'h0, e}, 32'h0000_0001);
        $display("test registers done");
        // emulation bits 5 and 6 are always written as zero
        for (int k = 0; k < 3; k++) begin
            apb(1, ZONE0_CFG_ADDR, {8'h0, 8'h80 | {hv[k], 3'b0} | wv[k]});
            apb(1, IO_CFG_ADDR, {8'h0, 8'h80 | {hv[k], 3'b0} | wv[k]});
            acc(16'h0100, 0, 0, 1 + wv[k], hv[k], 1);
            acc(16'h0200, 1, 0, 2 + wv[k], hv[k], 1);
            acc(16'hfb00, 0, 0, 1 + wv[k], hv[k], 1);
            acc(16'hfbff, 1, 0, 2 + wv[k], hv[k], 1);
        end
        chk({31'h0, bus_wide_16}, 32'h0000_0001);
        apb(1, MODE_CTRL_ADDR, 16'h0000);
        acc(16'h0300, 1, 0, 3, 1, 1);
        apb(0, STATUS_ADDR, 16'h0); chk(q, 32'h0000_0130);
        acc(16'hfb20, 1, 0, 3, 1, 1);
        acc(16'he000, 0, 0, 0, 0, 1);
        acc(16'he7fe, 1, 0, 0, 0, 1);
        acc(16'hf000, 0, 0, 1, 0, 1);
        acc(16'hf300, 0, 0, 1, 0, 1);
        acc(16'hfc00, 1, 0, 1, 0, 1);
        apb(1, MODE_CTRL_ADDR, 16'h0002);
        acc(16'hf27e, 0, 0, 0, 0, 1);
        $display("test zone timing done");
        apb(1, ZONE0_CFG_ADDR, 16'h089f);
        acc(16'h0000, 0, 0, 0, 0, 0);
        acc(16'hbffe, 1, 0, 1, 0, 1);
        apb(1, MODE_CTRL_ADDR, 16'h0003);
        acc(16'h0010, 1, 0, 2, 0, 1);
        apb(1, ZONE0_CFG_ADDR, 16'h0000);
        acc(16'h0020, 0, 0, 1, 0, 1);
        chk({31'h0, bus_wide_16}, 32'h0000_0000);
        $display("test fast read done");
        apb(1, ZONE0_CFG_ADDR, 16'h0280);
        acc(16'h0040, 0, 0, 1, 0, 1);
        acc(16'he010, 0, 1, 0, 0, 1);
        acc(16'he020, 0, 0, 0, 0, 1);
        apb(1, ZONE0_CFG_ADDR, 16'h0680);
        acc(16'h0050, 0, 1, 1, 0, 1);
        acc(16'he030, 0, 2, 0, 0, 1);
        $display("test idle cycles done");
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        apb(0, ZONE0_CFG_ADDR, 16'h0); chk(q, 32'h0000_069f);
        apb(0, IO_CFG_ADDR, 16'h0); chk(q, 32'h0000_069f);
        acc(16'h0100, 0, 1, 8, 3, 1);
        $display("test second reset done");
        close_out();
    end
endmodule : test_bus_wait_hold_timing
